/* File: core/acs_control_sequencer.sv */
// Control register and conversion sequencer for a multi-channel ADC
`default_nettype none
module acs_control_sequencer #(
  parameter int STEP_CYCLES = acs_pkg::ACS_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] ctrl_addr_i,
  input wire logic ctrl_wr_i,
  input wire logic [31:0] ctrl_wdata_i,
  output logic [31:0] ctrl_rdata_o,
  input wire logic [acs_pkg::ACS_NCH-1:0] oneshot_channel_mask_i,
  input wire logic [acs_pkg::ACS_NCH-1:0] periodic_channel_mask_i,
  input wire logic [acs_pkg::ACS_DLY_W-1:0] start_delay_i,
  input wire logic [acs_pkg::ACS_DLY_W-1:0] repeat_interval_i,
  input wire logic [acs_pkg::ACS_NCH-1:0] channel_done_clear_i,
  output logic [acs_pkg::ACS_NCH-1:0] channel_done_flags_o,
  input wire logic [acs_pkg::ACS_CW-1:0] reading_sel_i,
  output logic [acs_pkg::ACS_DW-1:0] reading_o,
  output logic single_done_irq_o,
  output logic repeat_done_irq_o,
  output acs_pkg::acs_core_req_t core_req_o,
  input wire acs_pkg::acs_core_rsp_t core_rsp_i
);
  import acs_pkg::*;

  // Channel index of a one-hot vector
  function automatic logic [ACS_CW-1:0] enc(input logic [ACS_NCH-1:0] oh);
    logic [ACS_CW-1:0] idx;
    idx = '0;
    for (int i = 0; i < ACS_NCH; i++) begin
      if (oh[i]) idx = ACS_CW'(i);
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic enable_reg, run_reg, psd_reg, soft_reg;
  logic single_pend_reg, rpt_pend_reg, sdone_reg, rdone_reg;
  logic arm_prev_reg, cyc_rpt_reg;
  logic [ACS_NCH-1:0] rem_reg, low_reg, flags_reg;
  logic [31:0] rdata_reg;
  logic [ACS_DW-1:0] reading_reg;
  logic [ACS_DW-1:0] reading_mem [ACS_NCH];
  acs_state_t state_reg, state_next;
  acs_core_req_t core_reg, core_next;
  logic tmr_expire;

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode
  wire wr_ctrl = ctrl_wr_i && (ctrl_addr_i == ACS_CTRL_OFS);
  wire enable_next = wr_ctrl ? ctrl_wdata_i[ACS_BIT_ENABLE] : enable_reg;
  wire run_next = wr_ctrl ? ctrl_wdata_i[ACS_BIT_RUN] : run_reg;
  wire psd_next = wr_ctrl ? ctrl_wdata_i[ACS_BIT_PSD] : psd_reg;
  wire soft_next = wr_ctrl ? ctrl_wdata_i[ACS_BIT_SOFTRST] : soft_reg;
  wire clr_sdone = wr_ctrl && ctrl_wdata_i[ACS_BIT_SDONE];
  wire clr_rdone = wr_ctrl && ctrl_wdata_i[ACS_BIT_RDONE];
  wire enable_rise = enable_next && !enable_reg;
  // Trigger is judged against the values being written, so enable and
  // trigger may arrive in the same write
  wire go_new = enable_next && !soft_next;
  wire go_now = enable_reg && !soft_reg;
  wire single_req = wr_ctrl && ctrl_wdata_i[ACS_BIT_ONESHOT] && go_new;

  // Engine events
  wire idle = (state_reg == ACS_ST_IDLE);
  wire scan = (state_reg == ACS_ST_SCAN);
  wire conv = (state_reg == ACS_ST_CONV);
  wire [ACS_NCH-1:0] low_pick = rem_reg & (~rem_reg + 8'h01);
  wire start_single = idle && go_now && single_pend_reg;
  wire start_repeat = idle && go_now && !single_pend_reg
                      && rpt_pend_reg;
  wire start_any = start_single || start_repeat;
  wire finish = scan && (rem_reg == '0);
  wire set_sdone = finish && !cyc_rpt_reg;
  wire set_rdone = finish && cyc_rpt_reg;
  wire conv_done = conv && core_rsp_i.done;

  // Periodic scheduler arming
  wire arm_ok = run_reg && go_now;
  wire arm_rise = arm_ok && !arm_prev_reg;
  wire tmr_load = arm_rise || (set_rdone && arm_ok);
  wire [ACS_DLY_W-1:0] tmr_val = arm_rise ? start_delay_i : repeat_interval_i;

  // Pending flags and sticky done flags; on the done flags hardware set beats software clear
  wire single_pend_next = !go_new ? 1'b0 : single_req ? 1'b1 :
                          start_single ? 1'b0 : single_pend_reg;
  wire rpt_pend_next = !arm_ok ? 1'b0 : tmr_expire ? 1'b1 :
                       start_repeat ? 1'b0 : rpt_pend_reg;
  wire sdone_next = set_sdone ? 1'b1 :
                    (start_single || clr_sdone) ? 1'b0 : sdone_reg;
  wire rdone_next = set_rdone ? 1'b1 :
                    (start_repeat || clr_rdone) ? 1'b0 : rdone_reg;

  // Read view; reserved bits stay zero
  wire [31:0] ctrl_view = {24'h00_0000, sdone_next, rdone_next, 1'b0,
                           soft_next, psd_next, run_next, single_pend_next,
                           enable_next};

  ////////////////////////////////////////////////////////////////////////////
  // Step timer for start delay and repeat interval
  acs_step_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(!arm_ok),
    .load_i(tmr_load),
    .load_val_i(tmr_val),
    .expire_o(tmr_expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Engine next state; a disable lets the current cycle run out
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ACS_ST_IDLE: begin
        if (start_any) state_next = ACS_ST_SCAN;
      end
      ACS_ST_SCAN: begin
        state_next = finish ? ACS_ST_IDLE : ACS_ST_CONV;
      end
      ACS_ST_CONV: begin
        if (core_rsp_i.done) state_next = ACS_ST_SCAN;
      end
      default: state_next = ACS_ST_IDLE;
    endcase
    if (soft_reg) state_next = ACS_ST_IDLE;
  end

  // Core request; power held only while busy unless saver is off
  always_comb begin
    core_next = core_reg;
    core_next.reset = soft_next || enable_rise;
    core_next.start = scan && !finish && !soft_reg;
    core_next.channel = (scan && !finish) ? enc(low_pick) : core_reg.channel;
    core_next.power_en = (state_next != ACS_ST_IDLE)
                         || (enable_next && psd_next);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits; all clear on system reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {enable_reg, run_reg, psd_reg, soft_reg} <= 4'h0;
      {single_pend_reg, rpt_pend_reg} <= 2'h0;
      {sdone_reg, rdone_reg, arm_prev_reg} <= 3'h0;
      rdata_reg <= ACS_CTRL_RESET;
    end else begin
      {enable_reg, run_reg, psd_reg, soft_reg} <=
        {enable_next, run_next, psd_next, soft_next};
      {single_pend_reg, rpt_pend_reg} <= {single_pend_next, rpt_pend_next};
      {sdone_reg, rdone_reg, arm_prev_reg} <= {sdone_next, rdone_next, arm_ok};
      rdata_reg <= (ctrl_addr_i == ACS_CTRL_OFS) ? ctrl_view : 32'h0000_0000;
    end
  end

  // Engine registers; soft reset clears the engine, not the registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ACS_ST_IDLE;
      core_reg <= '0;
      {cyc_rpt_reg, rem_reg, low_reg} <= '0;
    end else begin
      state_reg <= state_next;
      core_reg <= core_next;
      if (start_any) begin
        cyc_rpt_reg <= start_repeat;
        rem_reg <= start_repeat ? periodic_channel_mask_i
                                : oneshot_channel_mask_i;
      end else if (scan && !finish) begin
        low_reg <= low_pick;
      end else if (conv_done) begin
        rem_reg <= rem_reg & ~low_reg;
      end
    end
  end

  // Sample store; the reading array needs no reset
  always_ff @(posedge clk_i) begin
    if (conv_done) reading_mem[core_reg.channel] <= core_rsp_i.data;
  end

  always_ff @(posedge clk_i) begin
    reading_reg <= rst_i ? '0 : reading_mem[reading_sel_i];
  end

  // Per-channel complete flags, set wins over write-one clear
  for (genvar g = 0; g < ACS_NCH; g++) begin : g_flag
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        flags_reg[g] <= 1'b0;
      end else if (conv_done && low_reg[g]) begin
        flags_reg[g] <= 1'b1;
      end else if (channel_done_clear_i[g]) begin
        flags_reg[g] <= 1'b0;
      end
    end
  end

  // Outputs
  assign ctrl_rdata_o = rdata_reg;
  assign channel_done_flags_o = flags_reg;
  assign reading_o = reading_reg;
  assign single_done_irq_o = sdone_reg;
  assign repeat_done_irq_o = rdone_reg;
  assign core_req_o = core_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_wc_clears: assert property (clr_sdone && !set_sdone |=> !sdone_reg)
    else $error("single done flag not cleared by write of one");
  a_rdone_clr: assert property (clr_rdone && !set_rdone
    |=> !repeat_done_irq_o)
    else $error("repeat done flag not cleared by write of one");
  a_w0_keeps: assert property (wr_ctrl && rdone_reg
    && !ctrl_wdata_i[ACS_BIT_RDONE] && !start_repeat |=> rdone_reg)
    else $error("repeat done flag lost on write of zero");
  a_sdone_start: assert property (start_single |=> !sdone_reg)
    else $error("single done flag survived cycle start");
  a_sdone_irq: assert property ($rose(single_done_irq_o)
    |-> $past(set_sdone))
    else $error("single interrupt rose without cycle end");
  a_rdone_start: assert property (start_repeat
    |=> !rdone_reg ##0 !repeat_done_irq_o)
    else $error("repeat done flag survived cycle start");
  a_rdone_set: assert property (set_rdone |=> rdone_reg)
    else $error("repeat done flag not set at cycle end");
  a_soft_hold: assert property (soft_next |=> core_req_o.reset)
    else $error("core not held in reset");
  a_soft_abort: assert property (soft_reg |=> idle)
    else $error("engine kept running under soft reset");
  a_soft_free: assert property (!soft_next && !enable_rise
    |=> !core_req_o.reset)
    else $error("core reset without cause");
  a_enable_pulse: assert property (enable_rise && !soft_next
    |=> core_req_o.reset ##1 (!core_req_o.reset || soft_reg
    || $past(enable_rise)))
    else $error("enable rise reset pulse wrong");
  a_idle_power: assert property (idle && !start_any && !psd_next
    |=> !core_req_o.power_en)
    else $error("core powered between sequences");
  a_off_power: assert property (idle && !start_any
    && !enable_next |=> !core_req_o.power_en)
    else $error("core powered while disabled and idle");
  a_start_gated: assert property (core_req_o.start
    |-> $past(enable_reg, 2) || !$past(idle, 2))
    else $error("conversion started while disabled");
  a_off_no_start: assert property (idle && !go_now |=> idle)
    else $error("cycle started while disabled or in soft reset");
  a_trig_clear: assert property (start_single && !single_req
    |=> !single_pend_reg)
    else $error("trigger bit did not clear");
  a_single_first: assert property (idle && go_now && single_pend_reg
    && rpt_pend_reg |=> scan && !cyc_rpt_reg)
    else $error("periodic cycle overtook one-shot");
  a_ascend: assert property (scan && !finish
    |-> ((low_pick - 8'h01) & rem_reg) == '0)
    else $error("channel order not ascending");
  a_run_stop: assert property (conv && !run_reg && !soft_reg
    |=> !idle)
    else $error("running cycle aborted");

  c_single: cover property (start_single ##[1:200] set_sdone);
  c_repeat: cover property (start_repeat ##[1:200] set_rdone);
  c_both: cover property (single_pend_reg && rpt_pend_reg && idle);
  c_stop: cover property (conv && $fell(enable_reg));
endmodule
`default_nettype wire

/* File: pkg/acs_pkg.sv */
// Constants and carrier types for the converter control sequencer
`default_nettype none
package acs_pkg;
  // Register map and control field positions
  localparam logic [7:0] ACS_CTRL_OFS = 8'h00;
  localparam int ACS_BIT_ENABLE = 0;
  localparam int ACS_BIT_ONESHOT = 1;
  localparam int ACS_BIT_RUN = 2;
  localparam int ACS_BIT_PSD = 3;
  localparam int ACS_BIT_SOFTRST = 4;
  localparam int ACS_BIT_RDONE = 6;
  localparam int ACS_BIT_SDONE = 7;
  localparam logic [31:0] ACS_CTRL_RESET = 32'h0000_0000;
  // Channel count and sample width
  localparam int ACS_NCH = 8;
  localparam int ACS_DW = 10;
  localparam int ACS_CW = 3;
  // Delay step timing, 40 us per step at a 250 MHz clock
  localparam int ACS_CLK_MHZ = 250;
  localparam int ACS_STEP_US = 40;
  localparam int ACS_STEP_CYC = ACS_STEP_US * ACS_CLK_MHZ;
  localparam int ACS_DLY_W = 16;

  // Request toward the analog core and its multiplexer
  typedef struct packed {
    logic power_en;
    logic reset;
    logic start;
    logic [ACS_CW-1:0] channel;
  } acs_core_req_t;

  // Answer from the analog core
  typedef struct packed {
    logic done;
    logic [ACS_DW-1:0] data;
  } acs_core_rsp_t;

  // Conversion engine states
  typedef enum logic [1:0] {
    ACS_ST_IDLE,
    ACS_ST_SCAN,
    ACS_ST_CONV
  } acs_state_t;
endpackage
`default_nettype wire

/* File: core/acs_step_timer.sv */
// Delay timer counting in 40 us steps for the periodic scheduler
`default_nettype none
module acs_step_timer #(
  parameter int STEP_CYCLES = acs_pkg::ACS_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [acs_pkg::ACS_DLY_W-1:0] load_val_i,
  output logic expire_o
);
  import acs_pkg::*;

  localparam logic [15:0] PRE_LAST = 16'(STEP_CYCLES - 1);

  logic [15:0] pre_reg;
  logic [ACS_DLY_W-1:0] cnt_reg;
  logic busy_reg;
  logic fire_reg;
  wire tick = busy_reg && (pre_reg == PRE_LAST);
  wire last_step = tick && (cnt_reg == 16'h0001);
  wire zero_load = load_i && (load_val_i == 16'h0000);

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler restarts on load so the first step is a full 40 us
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || load_i || !busy_reg || tick) begin
      pre_reg <= 16'h0000;
    end else begin
      pre_reg <= pre_reg + 16'h0001;
    end
  end

  // Step counter; a zero load expires at once
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
      fire_reg <= 1'b0;
    end else begin
      busy_reg <= load_i ? !zero_load : (busy_reg && !last_step);
      cnt_reg <= load_i ? load_val_i : (tick ? cnt_reg - 16'h0001 : cnt_reg);
      fire_reg <= zero_load || (!load_i && last_step);
    end
  end

  assign expire_o = fire_reg;
endmodule
`default_nettype wire

/* File: tb/acs_core_model.sv */
// Behavioural analog core and multiplexer answering conversion starts
`default_nettype none
module acs_core_model import acs_pkg::*; #(
  parameter int LATENCY = 12
) (
  input wire logic clk_i,
  input wire acs_pkg::acs_core_req_t core_req_i,
  output acs_pkg::acs_core_rsp_t core_rsp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ACS_CW-1:0] ch_reg = '0;
  logic [ACS_DW-1:0] last_reg = '0;
  int cnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // One conversion at a time; reset or power loss drops it silently
  always @(posedge clk_i) begin
    core_rsp_o.done <= 1'b0;
    core_rsp_o.data <= ~last_reg; // Stale data never looks valid
    if (core_req_i.reset || !core_req_i.power_en) begin
      cnt <= 0;
    end else if (core_req_i.start) begin
      ch_reg <= core_req_i.channel;
      cnt <= LATENCY;
    end else if (cnt == 1) begin
      core_rsp_o.done <= 1'b1;
      core_rsp_o.data <= {ch_reg, 7'h2b};
      last_reg <= {ch_reg, 7'h2b};
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_acs_control_sequencer.sv */
// Self-checking bench for the converter control sequencer
`default_nettype none
module tb_acs_control_sequencer import acs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] wd;
    logic [31:0] ex;
    logic rs;
  } acs_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ctrl_wr_i = 1'b0;
  logic [7:0] ctrl_addr_i = 8'h00;
  logic [31:0] ctrl_wdata_i = 32'h0;
  logic [31:0] ctrl_rdata_o;
  logic [7:0] os_mask = 8'h00;
  logic [7:0] rp_mask = 8'h00;
  logic [7:0] flags;
  logic [15:0] sdly = 16'h0;
  logic [15:0] rint = 16'h0;
  logic [2:0] rsel = 3'h0;
  logic [9:0] reading;
  logic sirq;
  logic rirq;
  acs_core_req_t req;
  acs_core_rsp_t rsp;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int nstart = 0;
  int k;
  int n;
  int t0;
  logic [2:0] chlog[$];
  // Reserved bits and a trigger under soft reset must not stick
  acs_row_t rows [3] = '{
    '{32'hffff_ff2c, 32'h0000_000c, 1'b0},
    '{32'h0000_001b, 32'h0000_0019, 1'b1},
    '{32'h0000_0000, 32'h0000_0000, 1'b0}};

  acs_control_sequencer #(.STEP_CYCLES(4)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .ctrl_addr_i(ctrl_addr_i), .ctrl_wr_i(ctrl_wr_i),
    .ctrl_wdata_i(ctrl_wdata_i), .ctrl_rdata_o(ctrl_rdata_o),
    .oneshot_channel_mask_i(os_mask), .periodic_channel_mask_i(rp_mask),
    .start_delay_i(sdly), .repeat_interval_i(rint),
    .channel_done_clear_i(8'h00), .channel_done_flags_o(flags),
    .reading_sel_i(rsel), .reading_o(reading),
    .single_done_irq_o(sirq), .repeat_done_irq_o(rirq),
    .core_req_o(req), .core_rsp_i(rsp));
  acs_core_model core (.clk_i(clk_i), .core_req_i(req), .core_rsp_o(rsp));

  ////////////////////////////////////////////////////////////////////////////
  initial forever #2 clk_i = ~clk_i;

  // Log every conversion start; cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (req.start === 1'b1) begin
      chlog.push_back(req.channel);
      nstart++;
    end
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [31:0] d);
    ctrl_wdata_i = d;
    ctrl_wr_i = 1'b1;
    tick(1);
    ctrl_wr_i = 1'b0;
    tick(1);
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] ex);
    total_checks++;
    if (got !== ex) begin
      err_count++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, ex);
    end
  endtask
  task automatic chk_bit(input logic got, input logic ex);
    total_checks++;
    if (got !== ex) begin
      err_count++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, ex);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; every wait is bounded
  initial begin
    tick(6);
    rst_i = 1'b0;
    chk_reg(ctrl_rdata_o, 32'h0);
    chk_reg({sirq, rirq, req}, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].wd);
      tick(2);
      chk_reg(ctrl_rdata_o, rows[i].ex);
      chk_bit(req.reset, rows[i].rs);
    end
    chk_reg(nstart, 0);
    ctrl_addr_i = 8'h04;
    tick(2);
    chk_reg(ctrl_rdata_o, 32'h0);
    ctrl_addr_i = 8'h00;
    // Enable rise pulses core reset; idle power follows bit 3
    n = 0;
    ctrl_wdata_i = 32'h01;
    ctrl_wr_i = 1'b1;
    tick(1);
    ctrl_wr_i = 1'b0;
    for (k = 0; k < 3; k++) begin
      n = n | int'(req.reset);
      tick(1);
    end
    chk_bit(n[0], 1'b1);
    chk_bit(req.power_en, 1'b0);
    wr(32'h09);
    tick(2);
    chk_bit(req.power_en, 1'b1);
    // One-shot over a sparse mask
    os_mask = 8'ha4;
    chlog.delete();
    wr(32'h03);
    for (k = 0; k < 400 && sirq !== 1'b1; k++) tick(1);
    chk_reg(chlog.size(), 3);
    chk_reg({chlog[0], chlog[1], chlog[2]}, {3'd2, 3'd5, 3'd7});
    chk_bit(sirq, 1'b1);
    tick(1);
    chk_reg(ctrl_rdata_o, 32'h81);
    chk_reg(flags, 8'ha4);
    rsel = 3'd5;
    tick(2);
    chk_reg(reading, 10'h2ab);
    wr(32'h01);
    chk_bit(ctrl_rdata_o[7], 1'b1);
    wr(32'h03);
    tick(2);
    chk_bit(ctrl_rdata_o[7], 1'b0);
    for (k = 0; k < 400 && sirq !== 1'b1; k++) tick(1);
    wr(32'h81);
    tick(1);
    chk_bit(ctrl_rdata_o[7], 1'b0);
    chk_bit(sirq, 1'b0);
    // Periodic with start delay, then a one-shot queued behind it
    os_mask = 8'h80;
    rp_mask = 8'h03;
    sdly = 16'd2;
    rint = 16'd3;
    n = nstart;
    t0 = cyc;
    wr(32'h05);
    for (k = 0; k < 400 && nstart == n; k++) tick(1);
    chk_bit((cyc - t0) >= 9 && (cyc - t0) <= 18, 1'b1);
    for (k = 0; k < 400 && rirq !== 1'b1; k++) tick(1);
    chk_bit(rirq, 1'b1);
    for (k = 0; k < 400 && ctrl_rdata_o[6] !== 1'b0; k++) tick(1);
    chk_bit(ctrl_rdata_o[6], 1'b0);
    wr(32'h07);
    for (k = 0; k < 400 && !(req.start === 1'b1 && req.channel == 3'd7);
         k++) tick(1);
    // Second trigger lands before the repeat request; both are pending when this cycle ends
    wr(32'h07);
    for (k = 0; k < 400 && sirq !== 1'b1; k++) tick(1);
    n = chlog.size();
    chk_reg({chlog[n-3], chlog[n-2], chlog[n-1]}, {3'd0, 3'd1, 3'd7});
    // Stop run mid-cycle: that cycle ends, no more follow
    for (k = 0; k < 400 && ctrl_rdata_o[6] !== 1'b0; k++) tick(1);
    wr(32'h01);
    for (k = 0; k < 400 && rirq !== 1'b1; k++) tick(1);
    chk_bit(rirq, 1'b1);
    n = chlog.size();
    chk_reg({chlog[n-3], chlog[n-2], chlog[n-1]}, {3'd7, 3'd0, 3'd1});
    n = nstart;
    tick(100);
    chk_reg(nstart, n);
    // Disable mid-cycle, then a trigger while disabled
    os_mask = 8'h0e;
    wr(32'hc1);
    n = nstart;
    wr(32'h03);
    wr(32'h00);
    for (k = 0; k < 400 && sirq !== 1'b1; k++) tick(1);
    chk_reg(nstart - n, 3);
    tick(4);
    chk_reg(ctrl_rdata_o, 32'h80);
    chk_bit(req.power_en, 1'b0);
    n = nstart;
    wr(32'h02);
    tick(50);
    chk_reg(nstart, n);
    chk_reg(ctrl_rdata_o, 32'h80);
    give_verdict();
  end
endmodule
`default_nettype wire
